// >>> verilog/mps_sequencer.sv
// microinstruction sequencer: fetch, latch, branch decode, return stack, power-up trap
// assumes the ROM word is valid on ROM_DATA_I by the end of the latch phase, where it is sampled
`timescale 1ns/1ps
// Function
// - each machine cycle runs from cycle-start strobe to instruction-latch strobe
// - power-up request drives reset-to-vector and trap-select low at execute strobe
// - active reset-to-vector clears the ROM address counter to zero
// - read phase presents counter address to ROM and pulses ROM read
// - instruction-latch strobe captures the ROM word into the output latch
// - opcode 1011 decodes as unconditional branch
// - jump gives decoder code 3, jump decode, both load halves active
// - both load halves active: counter loads at execute strobe, no count
// - trap-select picks hardwired vector one; that strobe releases reset-to-vector
// - opcode 1010 decodes as subroutine branch to instruction target
// - decoder enabled only while inverted top instruction bit is low
// - call gives decoder code 2, call decode, both load halves active
// - instruction bits 15 to 0 form the branch target
// - call writes counter to stack at cycle start, then decrements stack pointer
// - return stack has sixteen entries and wraps circularly
// - non-branch execute strobe increments counter by one
module mps_sequencer
    import mps_pkg::*;
(
    // clock and reset
    input wire logic CLK_I,
    input wire logic RESET_I,
    // power-up request pin
    input wire logic POWER_UP_VECTOR_REQUEST_I,
    // rom array
    output logic [mps_pkg::ADDR_W-1:0] ROM_ADDR_O,
    output logic ROM_READ_O,
    input wire logic [mps_pkg::INSTR_W-1:0] ROM_DATA_I,
    // strobes and decode state
    output logic CYCLE_START_STROBE_O,
    output logic EXECUTE_STROBE_O,
    output logic INSTR_LATCH_STROBE_O,
    output logic [mps_pkg::INSTR_W-1:0] INSTR_O,
    output logic JUMP_DECODE_N_O,
    output logic CALL_DECODE_N_O,
    output logic TARGET_LOAD_HIGH_N_O,
    output logic TARGET_LOAD_LOW_N_O,
    output logic RESET_TO_VECTOR_N_O,
    output logic TRAP_SELECT_N_O,
    output logic [mps_pkg::STACK_AW-1:0] STACK_PTR_O
);
    import mps_pkg::*;

    mps_phase_type phase;
    logic req_meta, req_sync;
    logic [ADDR_W-1:0] rom_address_counter;
    logic [INSTR_W-1:0] instr;
    logic reset_to_vector_n, trap_select_n;
    logic [ADDR_W-1:0] return_address_stack [STACK_DEPTH];
    logic [STACK_AW-1:0] stack_ptr;
    logic [2:0] dec_code;
    logic vector_sel;
    logic dec_en, jump_decode_n, call_decode_n, load_n;
    logic [ADDR_W-1:0] next_addr;
    logic st_start, st_exec, st_latch;

    function automatic logic [2:0] branch_code(input logic [INSTR_W-1:0] w);
        branch_code = w[OPCODE_MSB-1:OPCODE_LSB];
    endfunction : branch_code

    // pin is asynchronous to the cycle clock
    // reset stands for power being applied, so the request reads active until sampled
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            req_meta <= 1'b1;
            req_sync <= 1'b1;
        end else begin
            req_meta <= POWER_UP_VECTOR_REQUEST_I;
            req_sync <= req_meta;
        end
    end

    // four-phase machine cycle
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            phase <= PH_START;
        end else begin
            case (phase)
                // the counter moves before the read, so a taken branch has no delay slot
                PH_START: phase <= PH_EXEC;
                PH_EXEC: phase <= PH_READ;
                PH_READ: phase <= PH_LATCH;
                PH_LATCH: phase <= PH_START;
                default: phase <= PH_START;
            endcase
        end
    end

    assign st_start = (phase == PH_START);
    assign st_exec = (phase == PH_EXEC);
    assign st_latch = (phase == PH_LATCH);

    // inverted top bit low means top bit high in the true-polarity latch
    assign dec_en = instr[OPCODE_MSB];
    assign dec_code = branch_code(instr);
    assign jump_decode_n = ~(dec_en && instr[OPCODE_MSB-1:OPCODE_LSB] == OP_JUMP[2:0]
        && dec_code == 3'(DEC_JUMP_CODE));
    assign call_decode_n = ~(dec_en && instr[OPCODE_MSB-1:OPCODE_LSB] == OP_CALL[2:0]
        && dec_code == 3'(DEC_CALL_CODE));
    assign load_n = jump_decode_n & call_decode_n;

    // trap-select with reset-to-vector still low chooses the hardwired vector, else instruction bits 15..0
    // trap-select rises at the strobe after reset-to-vector rises; that strobe takes the target
    assign vector_sel = !trap_select_n && !reset_to_vector_n;
    assign next_addr = vector_sel ? TRAP_VECTOR : instr[ADDR_W-1:0];

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            reset_to_vector_n <= 1'b1;
            trap_select_n <= 1'b1;
        end else if (st_exec) begin
            if (req_sync) begin
                reset_to_vector_n <= 1'b0;
                trap_select_n <= 1'b0;
            end else begin
                reset_to_vector_n <= 1'b1;
                if (reset_to_vector_n) begin
                    trap_select_n <= 1'b1;
                end
            end
        end
    end

    // the strobe that releases reset-to-vector loads the vector if a branch decodes, else counts, so the vector is taken once
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            rom_address_counter <= ADDR_RESET;
        end else if (st_exec) begin
            if (req_sync) begin
                rom_address_counter <= ADDR_RESET;
            end else if (!load_n) begin
                rom_address_counter <= next_addr;
            end else begin
                rom_address_counter <= rom_address_counter + 16'h0001;
            end
        end else if (!reset_to_vector_n) begin
            rom_address_counter <= ADDR_RESET;
        end
    end

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            instr <= INSTR_RESET;
        end else if (st_latch) begin
            instr <= ROM_DATA_I;
        end
    end

    // write first, then step down; pointer wraps so overflow is silent
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            stack_ptr <= STACK_PTR_RESET;
        end else if (st_start && !call_decode_n) begin
            stack_ptr <= stack_ptr - 4'h1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (st_start && !call_decode_n) begin
            return_address_stack[stack_ptr] <= rom_address_counter;
        end
    end

    assign ROM_ADDR_O = rom_address_counter;
    assign ROM_READ_O = (phase == PH_READ);
    assign CYCLE_START_STROBE_O = st_start;
    assign EXECUTE_STROBE_O = st_exec;
    assign INSTR_LATCH_STROBE_O = st_latch;
    assign INSTR_O = instr;
    assign JUMP_DECODE_N_O = jump_decode_n;
    assign CALL_DECODE_N_O = call_decode_n;
    assign TARGET_LOAD_HIGH_N_O = load_n;
    assign TARGET_LOAD_LOW_N_O = load_n;
    assign RESET_TO_VECTOR_N_O = reset_to_vector_n;
    assign TRAP_SELECT_N_O = trap_select_n;
    assign STACK_PTR_O = stack_ptr;

    a_cycle_order: assert property (@(posedge CLK_I) disable iff (RESET_I)
        st_start |=> st_exec ##1 ROM_READ_O ##1 st_latch ##1 st_start)
        else $error("machine cycle out of order");
    a_trap_entry: assert property (@(posedge CLK_I) disable iff (RESET_I)
        st_exec && req_sync |=> !reset_to_vector_n && !trap_select_n)
        else $error("power-up request did not set trap");
    a_counter_clear: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (!reset_to_vector_n && !st_exec) || (st_exec && req_sync)
        |=> rom_address_counter == ADDR_RESET)
        else $error("counter not cleared by reset-to-vector");
    a_read_addr: assert property (@(posedge CLK_I) disable iff (RESET_I)
        ROM_READ_O |=> $stable(ROM_ADDR_O) && st_latch)
        else $error("rom address moved during read phase");
    a_latch_capture: assert property (@(posedge CLK_I) disable iff (RESET_I)
        st_latch |=> instr == $past(ROM_DATA_I))
        else $error("instruction not latched");
    a_jump_decode: assert property (@(posedge CLK_I) disable iff (RESET_I)
        instr[19:16] == 4'hb |-> !jump_decode_n && !TARGET_LOAD_HIGH_N_O && !TARGET_LOAD_LOW_N_O)
        else $error("jump not decoded");
    a_call_decode: assert property (@(posedge CLK_I) disable iff (RESET_I)
        instr[19:16] == 4'ha |-> !call_decode_n && !TARGET_LOAD_HIGH_N_O)
        else $error("call not decoded");
    a_branch_load: assert property (@(posedge CLK_I) disable iff (RESET_I)
        st_exec && !req_sync && reset_to_vector_n && !load_n
        |=> rom_address_counter == $past(instr[15:0]))
        else $error("branch target not loaded");
    a_vector_load: assert property (@(posedge CLK_I) disable iff (RESET_I)
        st_exec && !req_sync && !reset_to_vector_n && !load_n
        |=> rom_address_counter == TRAP_VECTOR)
        else $error("trap vector not loaded");
    a_counter_step: assert property (@(posedge CLK_I) disable iff (RESET_I)
        st_exec && !req_sync && load_n
        |=> rom_address_counter == $past(rom_address_counter) + 16'h0001)
        else $error("counter did not increment");
    a_stack_step: assert property (@(posedge CLK_I) disable iff (RESET_I)
        st_start && !call_decode_n |=> stack_ptr == $past(stack_ptr) - 4'h1)
        else $error("stack pointer not decremented");

    c_power_up: cover property (@(posedge CLK_I) disable iff (RESET_I)
        !trap_select_n ##[1:20] trap_select_n);
    c_jump: cover property (@(posedge CLK_I) disable iff (RESET_I) st_exec && !jump_decode_n);
    c_call: cover property (@(posedge CLK_I) disable iff (RESET_I) st_start && !call_decode_n);
    c_wrap: cover property (@(posedge CLK_I) disable iff (RESET_I)
        st_start && !call_decode_n && stack_ptr == 4'h0);
endmodule : mps_sequencer

// >>> verilog/mps_pkg.sv
// package for the microprogram sequencer: cycle phases, opcodes, vectors
// assumes a single 40 MHz clock domain and a 20-bit microinstruction word
package mps_pkg;
    localparam int INSTR_W = 20;
    localparam int ADDR_W = 16;
    localparam int STACK_DEPTH = 16;
    localparam int STACK_AW = 4;
    localparam int OPCODE_MSB = 19;
    localparam int OPCODE_LSB = 16;
    localparam logic [3:0] OP_JUMP = 4'hb;
    localparam logic [3:0] OP_CALL = 4'ha;
    localparam logic [1:0] DEC_JUMP_CODE = 2'h3;
    localparam logic [1:0] DEC_CALL_CODE = 2'h2;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
    localparam logic [ADDR_W-1:0] TRAP_VECTOR = 16'h0001;
    localparam logic [INSTR_W-1:0] INSTR_RESET = 20'h00000;
    localparam logic [STACK_AW-1:0] STACK_PTR_RESET = 4'hf;
    typedef enum logic [1:0] {
        PH_START,
        PH_READ,
        PH_EXEC,
        PH_LATCH
    } mps_phase_type;
endpackage : mps_pkg

// >>> dv/mps_rom_model.sv
// behavioural microprogram rom with output latch for the sequencer bench
// assumes the sequencer raises its read line for one clock per machine cycle
`timescale 1ns/1ps
module mps_rom_model
    import mps_pkg::*;
(
    input wire logic clk_i,
    input wire logic [mps_pkg::ADDR_W-1:0] addr_i,
    input wire logic read_i,
    output logic [mps_pkg::INSTR_W-1:0] data_o
);
    logic [INSTR_W-1:0] word = 20'h00000;
    logic [1:0] age = 2'h3;
    function automatic logic [INSTR_W-1:0] rom_word(input logic [ADDR_W-1:0] a);
        case (a)
            16'h0000: return 20'hb0418;
            16'h0001: return 20'ha163b;
            16'h163b: return 20'h43c2a;
            16'h163c: return 20'h3b000;
            16'h163d: return 20'hbfffd;
            16'h0418: return 20'ha0418;
            default: return 20'h00000;
        endcase
    endfunction : rom_word
    always_ff @(posedge clk_i) begin
        if (read_i) begin
            word <= rom_word(addr_i);
            age <= 2'h0;
        end else if (age != 2'h3) begin
            age <= age + 2'h1;
        end
    end
    // word holds through latch and the next start only, then the lines go stale
    assign data_o = (age < 2'h2) ? word : ~word;
endmodule : mps_rom_model

// >>> dv/mps_sequencer_tb.sv
// self-checking bench: power-up trap, branches, counting, return stack wrap
// assumes the rom model in mps_rom_model.sv and the four-clock machine cycle
`timescale 1ns/1ps
module mps_sequencer_tb;
    import mps_pkg::*;
    logic CLK_I, RESET_I, POWER_UP_VECTOR_REQUEST_I;
    logic [ADDR_W-1:0] ROM_ADDR_O;
    logic [INSTR_W-1:0] ROM_DATA_I, INSTR_O;
    logic [STACK_AW-1:0] STACK_PTR_O, sp;
    logic ROM_READ_O, CYCLE_START_STROBE_O, EXECUTE_STROBE_O, INSTR_LATCH_STROBE_O;
    logic JUMP_DECODE_N_O, CALL_DECODE_N_O, TARGET_LOAD_HIGH_N_O, TARGET_LOAD_LOW_N_O;
    logic RESET_TO_VECTOR_N_O, TRAP_SELECT_N_O;
    int err_count = 0;
    int samples_checked = 0;
    mps_sequencer mps_sequencer_i (.CLK_I(CLK_I), .RESET_I(RESET_I),
        .POWER_UP_VECTOR_REQUEST_I(POWER_UP_VECTOR_REQUEST_I), .ROM_ADDR_O(ROM_ADDR_O),
        .ROM_READ_O(ROM_READ_O), .ROM_DATA_I(ROM_DATA_I),
        .CYCLE_START_STROBE_O(CYCLE_START_STROBE_O), .EXECUTE_STROBE_O(EXECUTE_STROBE_O),
        .INSTR_LATCH_STROBE_O(INSTR_LATCH_STROBE_O), .INSTR_O(INSTR_O),
        .JUMP_DECODE_N_O(JUMP_DECODE_N_O), .CALL_DECODE_N_O(CALL_DECODE_N_O),
        .TARGET_LOAD_HIGH_N_O(TARGET_LOAD_HIGH_N_O), .TARGET_LOAD_LOW_N_O(TARGET_LOAD_LOW_N_O),
        .RESET_TO_VECTOR_N_O(RESET_TO_VECTOR_N_O), .TRAP_SELECT_N_O(TRAP_SELECT_N_O),
        .STACK_PTR_O(STACK_PTR_O));
    mps_rom_model mps_rom_model_i (.clk_i(CLK_I), .addr_i(ROM_ADDR_O), .read_i(ROM_READ_O),
        .data_o(ROM_DATA_I));
    initial begin
        CLK_I = 1'b0;
        forever #12.5 CLK_I = ~CLK_I;
    end
    task automatic test_done();
        $display("mismatches %0d of %0d checks", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one machine cycle: decode seen at execute, new counter in the read phase, then latch
    task automatic step(input logic [15:0] nxt, input logic jn, input logic cn);
        int n;
        int starts;
        n = 0;
        starts = 0;
        while (EXECUTE_STROBE_O !== 1'b1 && n < 20) begin
            if (CYCLE_START_STROBE_O === 1'b1) starts++;
            @(negedge CLK_I);
            n++;
        end
        if (n >= 20) begin
            err_count++;
            test_done();
        end
        chk("start_strobe", 20'h1, 20'(starts));
        chk("jump_n", 20'(jn), 20'(JUMP_DECODE_N_O));
        chk("call_n", 20'(cn), 20'(CALL_DECODE_N_O));
        chk("load_hi_n", 20'(jn & cn), 20'(TARGET_LOAD_HIGH_N_O));
        chk("load_lo_n", 20'(jn & cn), 20'(TARGET_LOAD_LOW_N_O));
        @(negedge CLK_I);
        chk("read_strobe", 20'h1, 20'(ROM_READ_O));
        chk("counter", 20'(nxt), 20'(ROM_ADDR_O));
        @(negedge CLK_I);
        chk("latch_strobe", 20'h1, 20'(INSTR_LATCH_STROBE_O));
    endtask : step
    task automatic test_power_up();
        step(16'h0000, 1'b1, 1'b1);
        step(16'h0000, 1'b0, 1'b1);
        chk("rtt_n", 20'h0, 20'(RESET_TO_VECTOR_N_O));
        chk("trap_n", 20'h0, 20'(TRAP_SELECT_N_O));
        POWER_UP_VECTOR_REQUEST_I = 1'b0;
        step(TRAP_VECTOR, 1'b0, 1'b1);
        chk("rtt_n", 20'h1, 20'(RESET_TO_VECTOR_N_O));
        chk("trap_n", 20'h0, 20'(TRAP_SELECT_N_O));
    endtask : test_power_up
    task automatic test_branches();
        step(16'h163b, 1'b1, 1'b0);
        chk("stack_ptr", 20'he, 20'(STACK_PTR_O));
        chk("trap_n", 20'h1, 20'(TRAP_SELECT_N_O));
        step(16'h163c, 1'b1, 1'b1);
        step(16'h163d, 1'b1, 1'b1);
        chk("instr", 20'h3b000, INSTR_O);
        step(16'hfffd, 1'b0, 1'b1);
        step(16'hfffe, 1'b1, 1'b1);
        step(16'hffff, 1'b1, 1'b1);
        step(16'h0000, 1'b1, 1'b1);
        step(16'h0418, 1'b0, 1'b1);
    endtask : test_branches
    task automatic test_stack_wrap();
        sp = 4'hd;
        step(16'h0418, 1'b1, 1'b0);
        chk("stack_ptr", 20'(sp), 20'(STACK_PTR_O));
        for (int i = 0; i < 16; i++) begin
            step(16'h0418, 1'b1, 1'b0);
            sp = sp - 4'h1;
            chk("stack_ptr", 20'(sp), 20'(STACK_PTR_O));
        end
    endtask : test_stack_wrap
    initial begin
        RESET_I = 1'b1;
        POWER_UP_VECTOR_REQUEST_I = 1'b1;
        repeat (12) @(negedge CLK_I);
        RESET_I = 1'b0;
        test_power_up();
        test_branches();
        test_stack_wrap();
        test_done();
    end
endmodule : mps_sequencer_tb
